/* hdl/evchc_params.svh */
`ifndef EVCHC_PARAMS_SVH
`define EVCHC_PARAMS_SVH
`define EVCHC_CFG_ADDR 12'h020
`define EVCHC_STAT_ADDR 12'h024
`define EVCHC_CFG_RESET 32'h00008000
`define EVCHC_CFG_MASK 32'h0000CFFF
`define EVCHC_ON_REQ_BIT 15
`define EVCHC_STBY_BIT 14
`define EVCHC_EDGE_HI 11
`define EVCHC_EDGE_LO 10
`define EVCHC_PATH_HI 9
`define EVCHC_PATH_LO 8
`define EVCHC_SRC_HI 7
`define EVCHC_SRC_LO 0
`define EVCHC_PATH_SYNC 2'h0
`define EVCHC_PATH_RESYNC 2'h1
`define EVCHC_PATH_ASYNC 2'h2
`define EVCHC_EDGE_NONE 2'h0
`define EVCHC_EDGE_RISE 2'h1
`define EVCHC_EDGE_FALL 2'h2
`define EVCHC_EDGE_BOTH 2'h3
`define EVCHC_NUM_GEN 256
`endif

/* hdl/evchc_pkg.sv */
package evchc_pkg;
   typedef struct packed {
      logic clock_on_request;
      logic keep_running_in_sleep;
      logic [1:0] edge_kind_select;
      logic [1:0] route_path;
      logic [7:0] event_source_select;
   } evchc_cfg_s;
   typedef struct packed {
      evchc_cfg_s cfg;
      logic [1:0] sync_pipe;
      logic prev_level;
      logic event_out;
      logic [31:0] prdata;
   } evchc_state_s;
endpackage

/* hdl/evchc_top.sv */
// The APB slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "evchc_params.svh"
module evchc_top (
   // apb
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // system
   input wire logic in_standby,
   input wire logic clock_source_on,
   // events
   input wire logic [`EVCHC_NUM_GEN-1:0] gen_events,
   output logic event_out,
   output logic gclk_request,
   output logic channel_active
);
   evchc_pkg::evchc_state_s st_ff, nxt_st;
   logic wr_cfg, rd_acc, busy, sel_level, async_path;
   logic [31:0] cfg_word;

   function automatic logic [31:0] pack_cfg(input evchc_pkg::evchc_cfg_s c);
      logic [31:0] w;
      w = 32'h00000000;
      w[`EVCHC_ON_REQ_BIT] = c.clock_on_request;
      w[`EVCHC_STBY_BIT] = c.keep_running_in_sleep;
      w[`EVCHC_EDGE_HI:`EVCHC_EDGE_LO] = c.edge_kind_select;
      w[`EVCHC_PATH_HI:`EVCHC_PATH_LO] = c.route_path;
      w[`EVCHC_SRC_HI:`EVCHC_SRC_LO] = c.event_source_select;
      return w;
   endfunction

   // address decode shared by write, read and error paths
   function automatic logic is_cfg(input logic [11:0] a);
      return a == `EVCHC_CFG_ADDR;
   endfunction

   function automatic logic is_stat(input logic [11:0] a);
      return a == `EVCHC_STAT_ADDR;
   endfunction

   assign cfg_word = pack_cfg(st_ff.cfg);
   assign pready = 1'b1;
   // partial writes rejected so a half-updated channel never exists
   assign wr_cfg = psel && penable && pwrite && is_cfg(paddr) && (&pstrb);
   // read data loaded at the setup edge so it stands through the access phase
   assign rd_acc = psel && !penable && !pwrite;

   logic wr_bad, rd_bad;
   logic [31:0] stat_word;
   assign wr_bad = !(is_cfg(paddr) && (&pstrb));
   assign rd_bad = !(is_cfg(paddr) || is_stat(paddr));
   // error flagged only in the access phase, never in setup
   assign pslverr = psel && penable && (pwrite ? wr_bad : rd_bad);
   // status: event, active, clock request, busy
   assign stat_word = {28'h0000000, st_ff.event_out, channel_active, gclk_request, busy};
   assign channel_active = !in_standby || st_ff.cfg.keep_running_in_sleep;
   assign async_path = (st_ff.cfg.route_path == `EVCHC_PATH_ASYNC);
   assign sel_level = gen_events[st_ff.cfg.event_source_select];
   // busy while an event is in flight through the sync stages
   assign busy = sel_level || (|st_ff.sync_pipe) || st_ff.prev_level || st_ff.event_out;
   assign gclk_request = channel_active && clock_source_on &&
                         (st_ff.cfg.clock_on_request ? busy : 1'b1);

   always_comb begin
      nxt_st = st_ff;
      if (wr_cfg) begin
         nxt_st.cfg.clock_on_request = pwdata[`EVCHC_ON_REQ_BIT];
         nxt_st.cfg.keep_running_in_sleep = pwdata[`EVCHC_STBY_BIT];
         nxt_st.cfg.edge_kind_select = pwdata[`EVCHC_EDGE_HI:`EVCHC_EDGE_LO];
         nxt_st.cfg.route_path = pwdata[`EVCHC_PATH_HI:`EVCHC_PATH_LO];
         nxt_st.cfg.event_source_select = pwdata[`EVCHC_SRC_HI:`EVCHC_SRC_LO];
      end
      if (rd_acc) begin
         if (is_cfg(paddr)) begin
            nxt_st.prdata = cfg_word;
         end else if (is_stat(paddr)) begin
            nxt_st.prdata = stat_word;
         end else begin
            nxt_st.prdata = 32'h00000000;
         end
      end
      if (!channel_active) begin
         nxt_st.sync_pipe = 2'h0;
         nxt_st.prev_level = 1'b0;
         nxt_st.event_out = 1'b0;
      end else begin
         nxt_st.sync_pipe = {st_ff.sync_pipe[0], sel_level};
         nxt_st.prev_level = st_ff.sync_pipe[1];
         if (async_path) begin
            // async: level passes straight, no edge stage; edge field ignored
            nxt_st.event_out = sel_level;
         end else begin
            case (st_ff.cfg.edge_kind_select)
               `EVCHC_EDGE_NONE: nxt_st.event_out = 1'b0;
               `EVCHC_EDGE_RISE: nxt_st.event_out = st_ff.sync_pipe[1] && !st_ff.prev_level;
               `EVCHC_EDGE_FALL: nxt_st.event_out = !st_ff.sync_pipe[1] && st_ff.prev_level;
               `EVCHC_EDGE_BOTH: nxt_st.event_out = st_ff.sync_pipe[1] ^ st_ff.prev_level;
               default: nxt_st.event_out = 1'b0;
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // clock on request set at reset, everything else cleared
         st_ff <= '{cfg: '{clock_on_request: 1'b1,
                           keep_running_in_sleep: 1'b0,
                           edge_kind_select: 2'h0,
                           route_path: 2'h0,
                           event_source_select: 8'h00},
                    sync_pipe: 2'h0,
                    prev_level: 1'b0,
                    event_out: 1'b0,
                    prdata: 32'h00000000};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign prdata = st_ff.prdata;
   assign event_out = st_ff.event_out;

   a_reset_value: assert property (@(posedge pclk) $rose(presetn) |->
      cfg_word == `EVCHC_CFG_RESET) else $error("config reset value wrong");
   a_full_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr_cfg |=> cfg_word == ($past(pwdata) & `EVCHC_CFG_MASK)) else $error("write lost");
   a_part_write: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && !(&pstrb)) |=> $stable(cfg_word))
      else $error("partial write changed config");
   a_always_req: assert property (@(posedge pclk) disable iff (!presetn)
      (!st_ff.cfg.clock_on_request && channel_active && clock_source_on) |-> gclk_request)
      else $error("clock not held on");
   a_idle_noreq: assert property (@(posedge pclk) disable iff (!presetn)
      (st_ff.cfg.clock_on_request && !busy) |-> !gclk_request)
      else $error("clock requested while idle");
   a_stby_off: assert property (@(posedge pclk) disable iff (!presetn)
      (in_standby && !st_ff.cfg.keep_running_in_sleep) |-> !gclk_request ##1 !event_out)
      else $error("channel ran in standby");
   a_stby_run: assert property (@(posedge pclk) disable iff (!presetn)
      (in_standby && st_ff.cfg.keep_running_in_sleep) |-> channel_active)
      else $error("channel stopped in standby");
   sequence s_rise_in;
      !st_ff.sync_pipe[1] ##1 st_ff.sync_pipe[1];
   endsequence
   a_rise_edge: assert property (@(posedge pclk) disable iff (!presetn)
      (channel_active && !async_path && st_ff.cfg.edge_kind_select == `EVCHC_EDGE_RISE
      && wr_cfg == 1'b0) ##0 s_rise_in ##0 (channel_active && !wr_cfg) |=> event_out)
      else $error("rising edge missed");
   a_async_pass: assert property (@(posedge pclk) disable iff (!presetn)
      (channel_active && async_path && !wr_cfg) |=> event_out == $past(sel_level))
      else $error("async path not passed");

   sequence s_fall_in;
      st_ff.sync_pipe[1] ##1 !st_ff.sync_pipe[1];
   endsequence
   a_fall_edge: assert property (@(posedge pclk) disable iff (!presetn)
      (channel_active && !async_path && st_ff.cfg.edge_kind_select == `EVCHC_EDGE_FALL
      && !wr_cfg) ##0 s_fall_in ##0 (channel_active && !wr_cfg) |=> event_out)
      else $error("falling edge missed");

   a_no_edge: assert property (@(posedge pclk) disable iff (!presetn)
      (channel_active && !async_path && st_ff.cfg.edge_kind_select == `EVCHC_EDGE_NONE
      && !wr_cfg) |=> !event_out)
      else $error("event passed with no edge kind");

   a_part_err: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && !(&pstrb)) |-> pslverr)
      else $error("partial write not flagged");

   a_edge_field: assert property (@(posedge pclk) disable iff (!presetn)
      wr_cfg |=> st_ff.cfg.edge_kind_select == $past(pwdata[`EVCHC_EDGE_HI:`EVCHC_EDGE_LO]))
      else $error("edge field not stored");

   a_cfg_read: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && is_cfg(paddr)) |=> prdata == cfg_word)
      else $error("config read data wrong");

   a_stby_clear: assert property (@(posedge pclk) disable iff (!presetn)
      !channel_active |=> (st_ff.sync_pipe == 2'h0) && !st_ff.prev_level)
      else $error("pipeline kept in standby");

   a_src_gate: assert property (@(posedge pclk) disable iff (!presetn)
      !clock_source_on |-> !gclk_request)
      else $error("clock requested with source off");

   a_busy_req: assert property (@(posedge pclk) disable iff (!presetn)
      (st_ff.cfg.clock_on_request && sel_level && channel_active && clock_source_on)
      |-> gclk_request)
      else $error("clock not requested while busy");

   a_stby_clk: assert property (@(posedge pclk) disable iff (!presetn)
      (in_standby && st_ff.cfg.keep_running_in_sleep && !st_ff.cfg.clock_on_request
      && clock_source_on) |-> gclk_request)
      else $error("standby clock not held on");
endmodule // evchc_top
`default_nettype wire

/* tb/evchc_gen_model.sv */
`timescale 1ns/1ps
`default_nettype none
module evchc_gen_model (
   // control
   input wire logic pclk,
   input wire logic [7:0] sel,
   input wire logic lvl,
   // events
   output logic [255:0] gen_events
);
   // only the chosen generator is active; every other generator stays quiet
   always_ff @(posedge pclk) begin
      gen_events <= 256'h0;
      gen_events[sel] <= lvl;
   end
endmodule // evchc_gen_model
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, lvl;
   logic in_standby, clock_source_on, event_out, gclk_request, channel_active;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [255:0] gen_events;
   int err_count, num_checks;
   evchc_top i_evchc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .in_standby(in_standby),
      .clock_source_on(clock_source_on), .gen_events(gen_events), .event_out(event_out),
      .gclk_request(gclk_request), .channel_active(channel_active));
   evchc_gen_model i_evchc_gen_model (.pclk(pclk), .sel(8'h05), .lvl(lvl),
      .gen_events(gen_events));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one cycle idle after each transfer keeps every signal to one update per step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = {prdata[31:1], prdata[0] | 1'b0};
      rd[31] = prdata[31];
      chk({31'h0, pslverr}, {31'h0, w ? !(a == 12'h020 && s == 4'hF)
         : !(a == 12'h020 || a == 12'h024)});
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic see(input logic e);
      logic hit;
      hit = 1'b0;
      repeat (8) begin
         @(posedge pclk);
         if (event_out === 1'b1) hit = 1'b1;
      end
      chk({31'h0, hit}, {31'h0, e});
   endtask
   task automatic stop_test;
      $display("checks=%0d mismatches=%0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   initial begin
      repeat (3000) @(posedge pclk);
      err_count++;
      stop_test;
   end
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
      pwdata = 32'h0; pstrb = 4'h0; lvl = 1'b0; in_standby = 1'b0; clock_source_on = 1'b1;
      err_count = 0; num_checks = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 12'h020, 32'h0, 4'h0); chk(rd, 32'h00008000);
      apb(1'b1, 12'h020, 32'hFFFFFFFF, 4'hF);
      apb(1'b0, 12'h020, 32'h0, 4'h0); chk(rd, 32'h0000CFFF);
      apb(1'b1, 12'h020, 32'h00000000, 4'h3);
      apb(1'b0, 12'h020, 32'h0, 4'h0); chk(rd, 32'h0000CFFF);
      apb(1'b0, 12'h030, 32'h0, 4'h0); chk(rd, 32'h00000000);
      $display("register test done");
      apb(1'b1, 12'h020, 32'h00000405, 4'hF);
      chk({31'h0, gclk_request}, 32'h1);
      lvl <= 1'b1; see(1'b1);
      lvl <= 1'b0; see(1'b0);
      apb(1'b1, 12'h020, 32'h00008405, 4'hF);
      chk({31'h0, gclk_request}, 32'h0);
      lvl <= 1'b1;
      repeat (2) @(posedge pclk);
      chk({31'h0, gclk_request}, 32'h1);
      lvl <= 1'b0;
      repeat (8) @(posedge pclk);
      $display("sync path test done");
      apb(1'b1, 12'h020, 32'h00000205, 4'hF);
      lvl <= 1'b1; see(1'b1);
      lvl <= 1'b0;
      $display("async path test done");
      apb(1'b1, 12'h020, 32'h00000005, 4'hF);
      in_standby <= 1'b1;
      @(posedge pclk);
      chk({31'h0, channel_active}, 32'h0);
      chk({31'h0, gclk_request}, 32'h0);
      apb(1'b1, 12'h020, 32'h00004005, 4'hF);
      chk({31'h0, channel_active}, 32'h1);
      apb(1'b0, 12'h024, 32'h0, 4'h0); chk(rd, 32'h00000006);
      $display("standby test done");
      stop_test;
   end
endmodule // tb
`default_nettype wire
